//--- pkg/icc_defines.svh
`ifndef ICC_DEFINES_SVH
`define ICC_DEFINES_SVH

// register byte offsets on the bus
`define ICC_OFS_CTRL 5'h00
`define ICC_OFS_BUF 5'h04
`define ICC_OFS_STAT 5'h08
`define ICC_OFS_CLR 5'h0C
`define ICC_OFS_IEN 5'h10

// control register field positions
`define ICC_STOP_IDLE_BIT 13
`define ICC_TSEL_HI 12
`define ICC_TSEL_LO 10
`define ICC_CPI_HI 6
`define ICC_CPI_LO 5
`define ICC_OVF_BIT 4
`define ICC_BNE_BIT 3
`define ICC_MODE_HI 2
`define ICC_MODE_LO 0

// reset values
`define ICC_CTRL_RST 16'h0000
`define ICC_IEN_RST 3'h0

// event bits of status, clear and enable registers
`define ICC_EV_CAPTURE 0
`define ICC_EV_OVERFLOW 1
`define ICC_EV_WAKE 2

// mode codes
`define ICC_MODE_OFF 3'h0
`define ICC_MODE_ANY 3'h1
`define ICC_MODE_FALL 3'h2
`define ICC_MODE_RISE 3'h3
`define ICC_MODE_PRE4 3'h4
`define ICC_MODE_PRE16 3'h5
`define ICC_MODE_UNUSED 3'h6
`define ICC_MODE_WAKE 3'h7

// timebase select codes
`define ICC_TB_T2_ALT 3'h0
`define ICC_TB_T2 3'h1
`define ICC_TB_T4 3'h2
`define ICC_TB_T5 3'h3
`define ICC_TB_T1 3'h4
`define ICC_TB_SYS 3'h7

// prescaler terminal counts (edges minus one)
`define ICC_PRE4_LAST 4'h3
`define ICC_PRE16_LAST 4'hF

`endif

//--- pkg/icc_pkg.sv
package icc_pkg;
   // bus answer sequencer
   typedef enum logic {ICC_BUS_IDLE, ICC_BUS_ANSWER} icc_bus_state_t;
   // timebase word
   typedef logic [15:0] icc_word_t;
endpackage

//--- design/icc_mem.sv
`timescale 1ns/1ps
// small capture store, registered read port with write-through
module icc_mem #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4,
   parameter int AW = 2
) (
   input wire logic clk_i,
   input wire logic we_i,
   input wire logic [AW-1:0] waddr_i,
   input wire logic [WIDTH-1:0] wdata_i,
   input wire logic [AW-1:0] raddr_i,
   output logic [WIDTH-1:0] rdata_o
);
   logic [WIDTH-1:0] mem [DEPTH];  // storage, no reset needed

   // refused at elaboration: the pointers wrap on AW bits only
   if (DEPTH != (1 << AW)) begin : g_bad_depth
      $error("icc_mem: DEPTH must equal 2**AW");
   end

   // write port
   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
   end

   // read port; a write to the word being read passes straight through
   // so a push into an empty store is visible on the next cycle
   always_ff @(posedge clk_i) begin
      if (we_i && (waddr_i == raddr_i)) begin
         rdata_o <= wdata_i;
      end else begin
         rdata_o <= mem[raddr_i];
      end
   end
endmodule // icc_mem

//--- design/icc_top.sv
`timescale 1ns/1ps
`include "icc_defines.svh"
// Overview of operation
// [R1] stop-in-idle set halts channel during idle
// [R2] timebase select picks timer or system count
// [R3] interrupt every one to four captures
// [R4] any-edge mode ignores captures-per-interrupt
// [R5] overflow flag set by hardware only
// [R6] buffer-not-empty shows unread captures remain
// [R7] mode 111 is a sleep/idle wake pin
// [R8] modes 000 and 110 disable the channel
// [R9] mode 101 captures every sixteenth rising edge
// [R10] mode 100 captures every fourth rising edge
// [R11] 011 rising, 010 falling edge captures
// [R12] mode 001 captures on every edge
// [R13] software routes input through pin mapping
// [R14] capture pushes timebase; reads oldest first
// [R15] capture into full buffer sets overflow
module icc_top #(
   parameter int DEPTH = 4,  // capture buffer words
   parameter int AW = 2      // log2 of DEPTH
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [4:0] avm_address_i,
   input wire logic avm_read_i,
   input wire logic avm_write_i,
   input wire logic [31:0] avm_writedata_i,
   input wire logic [3:0] avm_byteenable_i,
   output logic [31:0] avm_readdata_o,
   output logic avm_waitrequest_o,
   input wire logic capture_input_i,
   input wire logic cpu_idle_i,
   input wire logic cpu_sleep_i,
   input wire icc_pkg::icc_word_t general_timer_one_i,
   input wire icc_pkg::icc_word_t general_timer_two_i,
   input wire icc_pkg::icc_word_t general_timer_four_i,
   input wire icc_pkg::icc_word_t general_timer_five_i,
   output logic irq_o
);
   import icc_pkg::*;

   // refused at elaboration: level and pointers assume a power of two
   if (DEPTH < 2 || DEPTH != (1 << AW)) begin : g_bad_depth
      $error("icc_top: DEPTH must be a power of two, at least 2");
   end

   // control register fields
   logic stop_in_idle;  // halt during cpu idle
   logic [2:0] timebase_select;
   logic [1:0] captures_per_interrupt;
   logic overflow_flag;  // hardware-only sticky
   logic [2:0] capture_mode_select;
   logic [2:0] irq_status;  // sticky events
   logic [2:0] irq_enable;
   icc_bus_state_t bus_state;

   // capture machinery
   logic capture_q;  // input one cycle ago
   logic [3:0] pre_cnt;  // rising edges seen by prescaler
   logic [1:0] cpi_cnt;  // captures since last interrupt
   logic [AW:0] level;  // words held in buffer
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   icc_word_t sys_cnt;  // system clock timebase
   icc_word_t buf_rdata;

   // bus decode
   wire logic bus_req = (avm_read_i | avm_write_i) &&
                        (bus_state == ICC_BUS_IDLE);
   wire logic bus_acc = (bus_state == ICC_BUS_ANSWER);
   wire logic wr_acc = bus_acc & avm_write_i;
   wire logic rd_acc = bus_acc & avm_read_i;
   wire logic sel_ctrl = (avm_address_i == `ICC_OFS_CTRL);
   wire logic sel_buf = (avm_address_i == `ICC_OFS_BUF);
   wire logic sel_stat = (avm_address_i == `ICC_OFS_STAT);
   wire logic sel_clr = (avm_address_i == `ICC_OFS_CLR);
   wire logic sel_ien = (avm_address_i == `ICC_OFS_IEN);
   wire logic wr_ctrl_lo = wr_acc & sel_ctrl & avm_byteenable_i[0];
   wire logic wr_ctrl_hi = wr_acc & sel_ctrl & avm_byteenable_i[1];
   wire logic [2:0] new_mode = avm_writedata_i[`ICC_MODE_HI:`ICC_MODE_LO];
   // a new mode restarts prescaler and capture counting
   wire logic mode_load = wr_ctrl_lo && (new_mode != capture_mode_select);

   // buffer state
   wire logic buf_empty = (level == '0);
   wire logic buf_full = (level == (AW + 1)'(DEPTH));
   wire logic buffer_not_empty = !buf_empty;  // [R6]

   // power state gating; wake mode ignores idle halt
   wire logic low_power = cpu_sleep_i | cpu_idle_i;
   wire logic halted = cpu_sleep_i | (stop_in_idle & cpu_idle_i);  // [R1]
   wire logic mode_wake = (capture_mode_select == `ICC_MODE_WAKE);
   // off and unused codes fall outside this range [R8]
   wire logic mode_cap = (capture_mode_select >= `ICC_MODE_ANY) &&
                         (capture_mode_select <= `ICC_MODE_PRE16);
   wire logic run = mode_cap & !halted;

   // edge detection on the already synchronous input
   wire logic rise = capture_input_i & !capture_q;
   wire logic fall = !capture_input_i & capture_q;
   wire logic mode_pre4 = (capture_mode_select == `ICC_MODE_PRE4);
   wire logic mode_pre16 = (capture_mode_select == `ICC_MODE_PRE16);
   wire logic mode_pre = mode_pre4 | mode_pre16;
   wire logic [3:0] pre_last = mode_pre16 ? `ICC_PRE16_LAST :
                               `ICC_PRE4_LAST;  // [R9] [R10]
   wire logic pre_hit = rise && (pre_cnt == pre_last);
   logic edge_hit;

   // qualifying edge per mode
   always_comb begin
      case (capture_mode_select)
         `ICC_MODE_ANY: edge_hit = rise | fall;  // [R12]
         `ICC_MODE_FALL: edge_hit = fall;  // [R11]
         `ICC_MODE_RISE: edge_hit = rise;  // [R11]
         `ICC_MODE_PRE4: edge_hit = pre_hit;  // [R10]
         `ICC_MODE_PRE16: edge_hit = pre_hit;  // [R9]
         default: edge_hit = 1'b0;  // [R8] [R7]
      endcase
   end

   wire logic capture_evt = run & edge_hit;
   wire logic push = capture_evt & !buf_full;  // [R14]
   wire logic ovf_set = capture_evt & buf_full;  // [R15]
   wire logic pop = rd_acc & sel_buf & !buf_empty;  // [R14]
   // any-edge mode interrupts on every stored capture [R4]
   wire logic any_mode = (capture_mode_select == `ICC_MODE_ANY);
   wire logic cpi_done = any_mode ||
                         (cpi_cnt == captures_per_interrupt);  // [R3]
   wire logic cap_irq_evt = push & cpi_done;
   wire logic wake_evt = mode_wake & low_power & rise;  // [R7]
   logic [15:0] push_data;

   // timebase select; reserved codes capture zero [R2]
   always_comb begin
      case (timebase_select)
         `ICC_TB_SYS: push_data = sys_cnt;
         `ICC_TB_T1: push_data = general_timer_one_i;
         `ICC_TB_T5: push_data = general_timer_five_i;
         `ICC_TB_T4: push_data = general_timer_four_i;
         `ICC_TB_T2: push_data = general_timer_two_i;
         `ICC_TB_T2_ALT: push_data = general_timer_two_i;
         default: push_data = 16'h0000;
      endcase
   end

   // read-back of the control word
   wire logic [15:0] ctrl_word = {2'b00, stop_in_idle, timebase_select,
      3'b000, captures_per_interrupt, overflow_flag, buffer_not_empty,
      capture_mode_select};
   wire logic [2:0] ev_set = {wake_evt, ovf_set, cap_irq_evt};
   wire logic [2:0] ev_clr = (wr_acc & sel_clr) ?
                             avm_writedata_i[2:0] : 3'b000;
   // set wins over a clear in the same cycle
   wire logic [2:0] next_status = (irq_status & ~ev_clr) | ev_set;
   wire logic [2:0] next_enable = (wr_acc & sel_ien & avm_byteenable_i[0]) ?
                                  avm_writedata_i[2:0] : irq_enable;
   // buffer word is read from the pointer that will stand after this edge
   wire logic [AW-1:0] next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
   logic [31:0] next_rdata;

   // read mux; unmapped and write-only addresses read zero
   always_comb begin
      next_rdata = 32'h0000_0000;
      if (sel_ctrl) begin
         next_rdata = {16'h0000, ctrl_word};
      end else if (sel_buf) begin
         next_rdata = {16'h0000, buf_rdata};
      end else if (sel_stat) begin
         next_rdata = {29'h0, irq_status};
      end else if (sel_ien) begin
         next_rdata = {29'h0, irq_enable};
      end
   end

   // bus answer: one wait cycle, then waitrequest low for one cycle
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bus_state <= ICC_BUS_IDLE;
         avm_waitrequest_o <= 1'b1;
         avm_readdata_o <= 32'h0000_0000;
      end else begin
         case (bus_state)
            ICC_BUS_IDLE: begin
               if (bus_req) begin
                  bus_state <= ICC_BUS_ANSWER;
                  avm_waitrequest_o <= 1'b0;
                  avm_readdata_o <= next_rdata;
               end
            end
            ICC_BUS_ANSWER: begin
               bus_state <= ICC_BUS_IDLE;
               avm_waitrequest_o <= 1'b1;
            end
            default: begin
               bus_state <= ICC_BUS_IDLE;
               avm_waitrequest_o <= 1'b1;
            end
         endcase
      end
   end

   // control register; status bits are hardware only
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         {stop_in_idle, timebase_select} <= 4'h0;
         captures_per_interrupt <= 2'h0;
         capture_mode_select <= `ICC_MODE_OFF;
      end else begin
         if (wr_ctrl_hi) begin
            stop_in_idle <= avm_writedata_i[`ICC_STOP_IDLE_BIT];
            timebase_select <= avm_writedata_i[`ICC_TSEL_HI:`ICC_TSEL_LO];
         end
         if (wr_ctrl_lo) begin
            captures_per_interrupt <=
               avm_writedata_i[`ICC_CPI_HI:`ICC_CPI_LO];
            capture_mode_select <= new_mode;
         end
      end
   end

   // overflow: set by a lost capture, cleared only by turning off [R5]
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         overflow_flag <= 1'b0;
      end else if (ovf_set) begin
         overflow_flag <= 1'b1;  // [R15]
      end else if (capture_mode_select == `ICC_MODE_OFF) begin
         overflow_flag <= 1'b0;  // [R5]
      end
   end

   // edge history and system clock timebase
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         capture_q <= 1'b0;
         sys_cnt <= 16'h0000;
      end else begin
         capture_q <= capture_input_i;
         sys_cnt <= sys_cnt + 16'h0001;  // [R2]
      end
   end

   // prescaler counts rising edges only while running
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pre_cnt <= 4'h0;
      end else if (mode_load || !mode_pre) begin
         pre_cnt <= 4'h0;
      end else if (run && rise) begin
         pre_cnt <= pre_hit ? 4'h0 : pre_cnt + 4'h1;  // [R9] [R10]
      end
   end

   // captures-per-interrupt counter; stored captures only
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cpi_cnt <= 2'h0;
      end else if (mode_load || !mode_cap) begin
         cpi_cnt <= 2'h0;
      end else if (push) begin
         cpi_cnt <= cpi_done ? 2'h0 : cpi_cnt + 2'h1;  // [R3]
      end
   end

   // buffer pointers; oldest word leaves first
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         level <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;  // [R14]
         end
         rd_ptr <= next_rd_ptr;
         case ({push, pop})
            2'b10: level <= level + 1'b1;
            2'b01: level <= level - 1'b1;
            default: level <= level;
         endcase
      end
   end

   // interrupt status, enable and level output
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_status <= 3'h0;
         irq_enable <= `ICC_IEN_RST;
         irq_o <= 1'b0;
      end else begin
         irq_status <= next_status;
         irq_enable <= next_enable;
         irq_o <= |(next_status & next_enable);
      end
   end

   icc_mem #(
      .WIDTH(16),
      .DEPTH(DEPTH),
      .AW(AW)
   ) u_mem (
      .clk_i(clk_i),
      .we_i(push),
      .waddr_i(wr_ptr),
      .wdata_i(push_data),
      .raddr_i(next_rd_ptr),
      .rdata_o(buf_rdata)
   );

   // checks; one clock domain, so clock and reset are given once
   default clocking chk_cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);
   sequence push_s;
      push;
   endsequence
   sequence lost_s;
      capture_evt && buf_full;
   endsequence

   idle_halt_a: assert property (  // [R1]
      stop_in_idle && cpu_idle_i |-> !capture_evt)
      else $error("capture while halted in idle");
   sys_tb_a: assert property (  // [R2]
      push_s ##0 (timebase_select == `ICC_TB_SYS) |->
      push_data == $past(sys_cnt) + 16'h0001)
      else $error("system timebase value wrong");
   cpi_irq_a: assert property (  // [R3]
      push_s ##0 (!any_mode && captures_per_interrupt == 2'h0) |=>
      irq_status[`ICC_EV_CAPTURE])
      else $error("no capture interrupt at count one");
   any_irq_a: assert property (  // [R4]
      push_s ##0 any_mode |=> irq_status[`ICC_EV_CAPTURE])
      else $error("any-edge capture gave no interrupt");
   // a read pop in the lost cycle lowers level legally
   ovf_flag_a: assert property (  // [R15]
      lost_s ##0 !pop |=> overflow_flag && $stable(level))
      else $error("overflow not flagged or word stored");
   bne_flag_a: assert property (  // [R6]
      push_s |=> ctrl_word[`ICC_BNE_BIT])
      else $error("buffer not shown non-empty");
   wake_only_a: assert property (  // [R7]
      mode_wake |-> !push && (wake_evt == (low_power && rise)))
      else $error("wake mode misbehaves");
   off_mode_a: assert property (  // [R8]
      capture_mode_select inside {`ICC_MODE_OFF, `ICC_MODE_UNUSED}
      |-> !capture_evt)
      else $error("capture while disabled");
   pre_count_a: assert property (  // [R10]
      push_s ##0 mode_pre4 |-> rise && pre_cnt == `ICC_PRE4_LAST)
      else $error("prescale four captured early");
   fall_only_a: assert property (  // [R11]
      capture_evt && capture_mode_select == `ICC_MODE_FALL |-> fall)
      else $error("falling mode captured on rise");
endmodule // icc_top

//--- test/icc_pin_src.sv
`timescale 1ns/1ps
// far-side pin driver: emits a burst of whole pulses on the capture pin
module icc_pin_src (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic go_i,
   input wire logic [4:0] pulses_i,
   input wire logic slow_i,
   output logic sig_o,
   output logic busy_o
);
   logic [5:0] left; // toggles still owed
   logic [1:0] ph; // hold cycles of the current level
   // pin idles low; fast bursts toggle every cycle, the hardest case
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sig_o <= 1'b0;
         busy_o <= 1'b0;
         left <= 6'h00;
         ph <= 2'h0;
      end else if (!busy_o) begin
         // software has routed the pin before any burst starts
         if (go_i && pulses_i != 5'h00) begin
            busy_o <= 1'b1;
            left <= {pulses_i, 1'b0};
            ph <= 2'h0;
         end
      end else if (ph != 2'h0) begin
         ph <= ph - 2'h1;
      end else if (left == 6'h00) begin
         busy_o <= 1'b0; // burst over, pin back low
      end else begin
         sig_o <= ~sig_o;
         left <= left - 6'h01;
         ph <= slow_i ? 2'h2 : 2'h0;
      end
   end
endmodule // icc_pin_src

//--- test/icc_top_tb.sv
`timescale 1ns/1ps
`include "icc_defines.svh"
module icc_top_tb;
   import icc_pkg::*;
   logic clk_i, rst_n_i, avm_read_i, avm_write_i, avm_waitrequest_o;
   logic [4:0] avm_address_i;
   logic [31:0] avm_writedata_i, avm_readdata_o;
   logic capture_input_i, cpu_idle_i, cpu_sleep_i, irq_o;
   icc_word_t t1, t2, t4, t5;
   logic go, slow, busy;
   logic [4:0] npul;
   int error_cnt = 0;
   int checks_done = 0;
   int seed = 30602;
   logic [31:0] exp_q[$], msk_q[$]; // read notes, oldest first
   icc_word_t val_q[$];
   icc_top i_icc_top (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .avm_address_i(avm_address_i), .avm_read_i(avm_read_i),
      .avm_write_i(avm_write_i), .avm_writedata_i(avm_writedata_i),
      .avm_byteenable_i(4'hF), .avm_readdata_o(avm_readdata_o),
      .avm_waitrequest_o(avm_waitrequest_o),
      .capture_input_i(capture_input_i), .cpu_idle_i(cpu_idle_i),
      .cpu_sleep_i(cpu_sleep_i), .general_timer_one_i(t1),
      .general_timer_two_i(t2), .general_timer_four_i(t4),
      .general_timer_five_i(t5), .irq_o(irq_o));
   icc_pin_src i_icc_pin_src (.clk_i(clk_i), .rst_n_i(rst_n_i), .go_i(go),
      .pulses_i(npul), .slow_i(slow), .sig_o(capture_input_i),
      .busy_o(busy));
   // clock at 25 MHz
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t mismatch got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // control word with the hardware status bits folded in
   function automatic logic [31:0] cv(input logic [2:0] m, tb,
      input logic [1:0] ci, input logic sidl, ov, ne);
      cv = 32'h0;
      cv[`ICC_MODE_HI:`ICC_MODE_LO] = m;
      cv[`ICC_TSEL_HI:`ICC_TSEL_LO] = tb;
      cv[`ICC_CPI_HI:`ICC_CPI_LO] = ci;
      cv[`ICC_STOP_IDLE_BIT] = sidl;
      cv[`ICC_OVF_BIT] = ov;
      cv[`ICC_BNE_BIT] = ne;
   endfunction
   // timebase the select code should route; reserved codes read zero
   function automatic logic [31:0] tbv(input int ts);
      case (ts)
         0, 1: tbv = {16'h0, t2};
         2: tbv = {16'h0, t4};
         3: tbv = {16'h0, t5};
         4: tbv = {16'h0, t1};
         default: tbv = 32'h0;
      endcase
   endfunction
   // bus cycles: hold everything until waitrequest is sampled low
   task automatic bus_wr(input logic [4:0] a, input logic [31:0] d);
      avm_address_i <= a;
      avm_writedata_i <= d;
      avm_write_i <= 1'b1;
      @(posedge clk_i iff avm_waitrequest_o === 1'b0);
      avm_write_i <= 1'b0;
      @(posedge clk_i); // a released strobe stands one edge
   endtask
   task automatic bus_rd(input logic [4:0] a, input logic [31:0] e, m);
      exp_q.push_back(e & m);
      msk_q.push_back(m);
      avm_address_i <= a;
      avm_read_i <= 1'b1;
      @(posedge clk_i iff avm_waitrequest_o === 1'b0);
      avm_read_i <= 1'b0;
      @(posedge clk_i); // a released strobe stands one edge
   endtask
   // read monitor: the completing edge carries the data
   always @(posedge clk_i) begin
      if (avm_read_i && avm_waitrequest_o === 1'b0 && exp_q.size() > 0)
         chk(avm_readdata_o & msk_q.pop_front(), exp_q.pop_front());
   end
   // one burst from the far side, then let the capture land
   task automatic pulse(input logic [4:0] n);
      go <= 1'b1;
      npul <= n;
      slow <= 1'($random(seed));
      @(posedge clk_i);
      go <= 1'b0;
      @(posedge clk_i iff busy === 1'b0);
      repeat (2) @(posedge clk_i);
   endtask
   // irq is registered: look at mid-cycle, resume on a rising edge
   task automatic irq_chk(input logic e);
      @(posedge clk_i);
      @(negedge clk_i);
      chk({31'h0, irq_o}, {31'h0, e});
      @(posedge clk_i);
   endtask
   task automatic drain; // pops on an empty store move nothing
      bus_wr(`ICC_OFS_CTRL, 32'h0);
      repeat (4) bus_rd(`ICC_OFS_BUF, 32'h0, 32'h0);
      bus_wr(`ICC_OFS_CLR, 32'h7);
   endtask
   // hang guard, well beyond the one to two thousand cycles of the run
   initial begin
      repeat (50000) @(posedge clk_i);
      error_cnt++;
      tally_and_finish;
   end
   int unsigned caps[7] = '{32, 16, 16, 4, 1, 0, 0};
   logic [2:0] modes[7] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h0};
   initial begin
      rst_n_i = 1'b0;
      {avm_read_i, avm_write_i, go, slow, cpu_idle_i, cpu_sleep_i} = 6'h0;
      avm_address_i = 5'h00;
      avm_writedata_i = 32'h0;
      npul = 5'h00;
      {t1, t2, t4, t5} = 64'h0;
      repeat (5) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      // reset values and an unmapped place
      bus_rd(`ICC_OFS_CTRL, 32'h0, 32'hFFFFFFFF);
      bus_rd(`ICC_OFS_IEN, 32'h0, 32'hFFFFFFFF);
      bus_rd(`ICC_OFS_STAT, 32'h0, 32'hFFFFFFFF);
      bus_rd(5'h14, 32'h0, 32'hFFFFFFFF);
      irq_chk(1'b0);
      $display("test reset done");
      // every timebase code, one capture each
      for (int ts = 0; ts < 8; ts++) begin
         {t1, t2, t4, t5} <= {$random(seed), $random(seed)};
         bus_wr(`ICC_OFS_CTRL, cv(3'h3, 3'(ts), 2'h0, 1'b0, 1'b0, 1'b0));
         pulse(5'h01);
         bus_rd(`ICC_OFS_CTRL, cv(3'h3, 3'(ts), 0, 0, 0, 1), 32'hFFFF);
         bus_rd(`ICC_OFS_BUF, tbv(ts), ts == 7 ? 32'h0 : 32'hFFFF);
         bus_rd(`ICC_OFS_CTRL, cv(3'h3, 3'(ts), 0, 0, 0, 0), 32'hFFFF);
      end
      $display("test timebase done");
      // each mode but wake against 16 pulses; four-deep store overflows past 4
      for (int i = 0; i < 7; i++) begin
         drain;
         bus_wr(`ICC_OFS_CTRL, cv(modes[i], 3'h1, 2'h0, 1'b0, 1'b0, 1'b0));
         pulse(5'h10);
         bus_rd(`ICC_OFS_CTRL, cv(modes[i], 3'h1, 0, 0, caps[i] > 4,
            caps[i] > 0), 32'hFFFF);
      end
      // sixteenth rising edge exactly: none after 15, one after 16
      drain;
      bus_wr(`ICC_OFS_CTRL, cv(3'h5, 3'h1, 2'h0, 1'b0, 1'b0, 1'b0));
      pulse(5'h0F);
      bus_rd(`ICC_OFS_CTRL, cv(3'h5, 3'h1, 0, 0, 0, 0), 32'hFFFF);
      pulse(5'h01);
      bus_rd(`ICC_OFS_CTRL, cv(3'h5, 3'h1, 0, 0, 0, 1), 32'hFFFF);
      $display("test modes done");
      // five captures into four places: oldest first, fifth lost
      drain;
      bus_wr(`ICC_OFS_CTRL, cv(3'h3, 3'h1, 2'h0, 1'b0, 1'b0, 1'b0));
      for (int k = 0; k < 5; k++) begin
         t2 <= 16'($random(seed));
         pulse(5'h01);
         if (k < 4) val_q.push_back(t2);
      end
      bus_rd(`ICC_OFS_CTRL, cv(3'h3, 3'h1, 0, 0, 1, 1), 32'hFFFF);
      bus_rd(`ICC_OFS_STAT, 32'h2, 32'h2);
      repeat (4) bus_rd(`ICC_OFS_BUF, {16'h0, val_q.pop_front()},
         32'hFFFF);
      bus_rd(`ICC_OFS_CTRL, cv(3'h3, 3'h1, 0, 0, 1, 0), 32'hFFFF);
      $display("test order done");
      // interrupt every one to four captures
      bus_wr(`ICC_OFS_IEN, 32'h1);
      for (int ci = 0; ci < 4; ci++) begin
         drain;
         bus_wr(`ICC_OFS_CTRL, cv(3'h3, 3'h1, 2'(ci), 0, 0, 0));
         for (int k = 0; k <= ci; k++) begin
            pulse(5'h01);
            irq_chk(k == ci);
         end
      end
      bus_wr(`ICC_OFS_IEN, 32'h0);
      irq_chk(1'b0);
      bus_wr(`ICC_OFS_IEN, 32'h1);
      irq_chk(1'b1);
      bus_wr(`ICC_OFS_CLR, 32'h1);
      irq_chk(1'b0);
      drain;
      bus_wr(`ICC_OFS_CTRL, cv(3'h1, 3'h1, 2'h3, 0, 0, 0));
      pulse(5'h01);
      irq_chk(1'b1);
      // six edges in all overflow four places; rises alone would not
      pulse(5'h02);
      bus_rd(`ICC_OFS_CTRL, cv(3'h1, 3'h1, 3, 0, 1, 1), 32'hFFFF);
      $display("test interrupt done");
      // stop-in-idle and sleep gate captures
      for (int c = 0; c < 3; c++) begin
         drain;
         cpu_idle_i <= (c < 2);
         cpu_sleep_i <= (c == 2);
         bus_wr(`ICC_OFS_CTRL, cv(3'h3, 3'h1, 0, c == 0, 0, 0));
         pulse(5'h01);
         bus_rd(`ICC_OFS_CTRL, cv(3'h3, 3'h1, 0, c == 0, 0, c == 1),
            32'hFFFF);
      end
      // wake pin: only asleep or idle, rising edge, nothing stored
      drain;
      cpu_sleep_i <= 1'b0;
      cpu_idle_i <= 1'b0;
      bus_wr(`ICC_OFS_IEN, 32'h4);
      bus_wr(`ICC_OFS_CTRL, cv(3'h7, 3'h1, 2'h3, 1'b1, 1'b0, 1'b0));
      pulse(5'h01);
      bus_rd(`ICC_OFS_STAT, 32'h0, 32'h4);
      cpu_sleep_i <= 1'b1;
      pulse(5'h01);
      bus_rd(`ICC_OFS_STAT, 32'h4, 32'h4);
      irq_chk(1'b1);
      bus_rd(`ICC_OFS_CTRL, cv(3'h7, 3'h1, 3, 1, 0, 0), 32'hFFFF);
      bus_wr(`ICC_OFS_STAT, 32'h2);
      bus_rd(`ICC_OFS_STAT, 32'h4, 32'h6);
      $display("test sleep done");
      tally_and_finish;
   end
endmodule // icc_top_tb
